//--- shared/pin_override_defines.vh
`ifndef PIN_OVERRIDE_DEFINES_VH
`define PIN_OVERRIDE_DEFINES_VH

// system clock, for turning times into cycle counts
`define SYS_CLK_HZ 50000000

// pin counts of the three port slices handled here
`define PB_WIDTH 8
`define PD_WIDTH 2
`define PE_WIDTH 2

// port B bit positions
`define PB_SS_BIT 0
`define PB_SCK_BIT 1
`define PB_MOSI_BIT 2
`define PB_MISO_BIT 3
`define PB_TIMER_LSB 4
`define PB_TIMER_MSB 7

// port D bit positions
`define PD_CAPTURE_BIT 0
`define PD_EXT_IRQ_BIT 1

// port E slice: index 0 is pin bit 6, index 1 is pin bit 7
`define PE_SERIAL_DO_IDX 0
`define PE_DIVIDED_SYSCLK_OUT_IDX 1

// reset values of the registered pad controls
`define PB_PAD_RST 8'h00
`define PD_PAD_RST 2'h0
`define PE_PAD_RST 2'h0

// clock output divider: system clock cycles per half period
`define DIVIDED_SYSCLK_OUT_HALF_CYCLES 1
`define DIVIDED_SYSCLK_OUT_CNT_WIDTH 4
`define DIVIDED_SYSCLK_OUT_CNT_ZERO 4'h0

`endif

//--- hw/pin_override_cell.v
`include "pin_override_defines.vh"

// generic per-pin override stage, bitwise over a port slice
module pin_override_cell #(
    parameter WIDTH = 8
) (
    input wire [WIDTH-1:0] i_dir_bits,
    input wire [WIDTH-1:0] i_out_bits,
    input wire i_global_pullup_disable,
    input wire i_sleep_din_off,
    input wire [WIDTH-1:0] i_pullup_override_en,
    input wire [WIDTH-1:0] i_pullup_override_val,
    input wire [WIDTH-1:0] i_direction_override_en,
    input wire [WIDTH-1:0] i_direction_override_val,
    input wire [WIDTH-1:0] i_value_override_en,
    input wire [WIDTH-1:0] i_value_override_val,
    input wire [WIDTH-1:0] i_din_override_en,
    input wire [WIDTH-1:0] i_din_override_val,
    input wire [WIDTH-1:0] i_pad_in,
    output wire [WIDTH-1:0] o_drive_en,
    output wire [WIDTH-1:0] o_drive_val,
    output wire [WIDTH-1:0] o_pullup_en,
    output wire [WIDTH-1:0] o_din
);
    wire [WIDTH-1:0] pullup_plain;
    wire [WIDTH-1:0] din_en;

    assign pullup_plain = ~i_dir_bits & i_out_bits & {WIDTH{~i_global_pullup_disable}};
    assign o_pullup_en = (i_pullup_override_en & i_pullup_override_val)
        | (~i_pullup_override_en & pullup_plain);
    assign o_drive_en = (i_direction_override_en & i_direction_override_val)
        | (~i_direction_override_en & i_dir_bits);
    assign o_drive_val = (i_value_override_en & i_value_override_val)
        | (~i_value_override_en & i_out_bits);
    // sleep clamps inputs low unless a peripheral asks to keep them awake
    assign din_en = (i_din_override_en & i_din_override_val)
        | (~i_din_override_en & {WIDTH{~i_sleep_din_off}});
    assign o_din = i_pad_in & din_en;
endmodule

//--- hw/clock_out_divider.v
`include "pin_override_defines.vh"

// divided system clock; runs from power-on reset only so it keeps
// toggling while the system reset is held
module clock_out_divider (
    input wire i_sys_clk,
    input wire i_por_arst_n,
    output reg o_clk_div
);
    reg [`DIVIDED_SYSCLK_OUT_CNT_WIDTH-1:0] cnt_reg;
    wire tick;

    assign tick = (cnt_reg == `DIVIDED_SYSCLK_OUT_HALF_CYCLES - 1);

    always @(posedge i_sys_clk or negedge i_por_arst_n) begin
        if (!i_por_arst_n) begin
            cnt_reg <= `DIVIDED_SYSCLK_OUT_CNT_ZERO;
            o_clk_div <= 1'b0;
        end else if (tick) begin
            cnt_reg <= `DIVIDED_SYSCLK_OUT_CNT_ZERO;
            o_clk_div <= ~o_clk_div;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule

//--- hw/port_alternate_function_override.v
// Notes on behaviour
// - serial slave forces data-in pin to input
// - serial slave forces clock pin to input
// - serial master: clock pin direction from its bit
// - serial master: data-out pin direction from its bit
// - slave forces select input; active while low
// - serial master: select pin direction from its bit
// - forced inputs keep pull-up from output bit
// - data pins split by master and slave role
// - pin-change sources keep inputs awake when masked
// - port D bit 1 feeds external interrupt zero
// - port D bit 0 feeds capture, no override
// - clock fuse drives divided clock on E7
// - divided clock output stays active during reset
// - port E bit 6 carries serial data output
// - plain pull-up needs input, one, no disable
// - direction override replaces direction bit
// - value override replaces output bit when driving
`include "pin_override_defines.vh"

module port_alternate_function_override (
    input wire i_sys_clk,
    input wire i_arst_n,
    input wire i_por_arst_n,
    input wire [`PB_WIDTH-1:0] i_pb_dir_bits,
    input wire [`PB_WIDTH-1:0] i_pb_out_bits,
    input wire [`PD_WIDTH-1:0] i_pd_dir_bits,
    input wire [`PD_WIDTH-1:0] i_pd_out_bits,
    input wire [`PE_WIDTH-1:0] i_pe_dir_bits,
    input wire [`PE_WIDTH-1:0] i_pe_out_bits,
    input wire i_global_pullup_disable,
    input wire i_sleep_din_off,
    input wire i_serial_periph_enable,
    input wire i_serial_master_select,
    input wire i_spi_serial_master_select_out,
    input wire i_spi_slave_out,
    input wire i_spi_sck_out,
    input wire [3:0] i_timer_cmp_en,
    input wire [3:0] i_timer_cmp_val,
    input wire [`PB_WIDTH-1:0] i_pb_change_mask,
    input wire i_pin_change_group1_enable,
    input wire [`PE_WIDTH-1:0] i_pe_change_mask,
    input wire i_pin_change_group0_enable,
    input wire i_ext_irq_zero_enable,
    input wire i_clock_output_fuse,
    input wire i_usi_three_wire,
    input wire i_usi_data_out,
    input wire [`PB_WIDTH-1:0] i_pb_pad_in,
    input wire [`PD_WIDTH-1:0] i_pd_pad_in,
    input wire [`PE_WIDTH-1:0] i_pe_pad_in,
    output wire [`PB_WIDTH-1:0] o_pb_pad_out,
    output wire [`PB_WIDTH-1:0] o_pb_pad_oe,
    output wire [`PB_WIDTH-1:0] o_pb_pullup,
    output wire [`PD_WIDTH-1:0] o_pd_pad_out,
    output wire [`PD_WIDTH-1:0] o_pd_pad_oe,
    output wire [`PD_WIDTH-1:0] o_pd_pullup,
    output wire [`PE_WIDTH-1:0] o_pe_pad_out,
    output wire [`PE_WIDTH-1:0] o_pe_pad_oe,
    output wire [`PE_WIDTH-1:0] o_pe_pullup,
    output wire [`PB_WIDTH-1:0] o_pb_pin_change_src,
    output wire [`PE_WIDTH-1:0] o_pe_pin_change_src,
    output wire o_ext_irq_zero,
    output wire o_capture_input_timer16,
    output wire o_spi_serial_master_select_in,
    output wire o_spi_slave_in,
    output wire o_spi_sck_in,
    output wire o_spi_slave_select_n,
    output wire o_spi_slave_active
);
    wire spi_master;
    wire spi_slave;
    wire divided_sysclk_out;

    // readable aliases for the serial pins of port B
    wire dir_bit_pb_bit0;
    wire dir_bit_pb_bit1;
    wire dir_bit_pb_bit2;
    wire out_bit_pb_bit0;
    wire out_bit_pb_bit1;
    wire out_bit_pb_bit2;
    wire out_bit_pb_bit3;
    wire forced_pullup_ok;
    wire [`PB_WIDTH-1:0] pb_dir_cell;

    reg [`PB_WIDTH-1:0] pb_pullup_override_en;
    reg [`PB_WIDTH-1:0] pb_puov;
    reg [`PB_WIDTH-1:0] pb_direction_override_en;
    reg [`PB_WIDTH-1:0] pb_value_override_en;
    reg [`PB_WIDTH-1:0] pb_value_override_val;
    wire [`PB_WIDTH-1:0] pb_dieoe;
    wire [`PB_WIDTH-1:0] pb_drive_en;
    wire [`PB_WIDTH-1:0] pb_drive_val;
    wire [`PB_WIDTH-1:0] pb_pullup_en;
    wire [`PB_WIDTH-1:0] pb_din;

    wire [`PD_WIDTH-1:0] pd_dieoe;
    wire [`PD_WIDTH-1:0] pd_dieov;
    wire [`PD_WIDTH-1:0] pd_drive_en;
    wire [`PD_WIDTH-1:0] pd_drive_val;
    wire [`PD_WIDTH-1:0] pd_pullup_en;
    wire [`PD_WIDTH-1:0] pd_din;

    reg [`PE_WIDTH-1:0] pe_direction_override_en;
    reg [`PE_WIDTH-1:0] pe_direction_override_val;
    reg [`PE_WIDTH-1:0] pe_value_override_en;
    reg [`PE_WIDTH-1:0] pe_value_override_val;
    wire [`PE_WIDTH-1:0] pe_dieoe;
    wire [`PE_WIDTH-1:0] pe_drive_en;
    wire [`PE_WIDTH-1:0] pe_drive_val;
    wire [`PE_WIDTH-1:0] pe_pullup_en;
    wire [`PE_WIDTH-1:0] pe_din;

    reg [`PB_WIDTH-1:0] pb_out_reg;
    reg [`PB_WIDTH-1:0] pb_oe_reg;
    reg [`PB_WIDTH-1:0] pb_pu_reg;
    reg [`PD_WIDTH-1:0] pd_out_reg;
    reg [`PD_WIDTH-1:0] pd_oe_reg;
    reg [`PD_WIDTH-1:0] pd_pu_reg;
    reg [`PE_WIDTH-1:0] pe_out_reg;
    reg [`PE_WIDTH-1:0] pe_oe_reg;
    reg [`PE_WIDTH-1:0] pe_pu_reg;

    assign spi_master = i_serial_periph_enable & i_serial_master_select;
    assign spi_slave = i_serial_periph_enable & ~i_serial_master_select;

    assign dir_bit_pb_bit0 = i_pb_dir_bits[`PB_SS_BIT];
    assign dir_bit_pb_bit1 = i_pb_dir_bits[`PB_SCK_BIT];
    assign dir_bit_pb_bit2 = i_pb_dir_bits[`PB_MOSI_BIT];
    assign out_bit_pb_bit0 = i_pb_out_bits[`PB_SS_BIT];
    assign out_bit_pb_bit1 = i_pb_out_bits[`PB_SCK_BIT];
    assign out_bit_pb_bit2 = i_pb_out_bits[`PB_MOSI_BIT];
    assign out_bit_pb_bit3 = i_pb_out_bits[`PB_MISO_BIT];
    // a forced input still honours the global pull-up disable
    assign forced_pullup_ok = ~i_global_pullup_disable;

    // port B override signals
    always @* begin
        pb_pullup_override_en = `PB_PAD_RST;
        pb_puov = `PB_PAD_RST;
        pb_direction_override_en = `PB_PAD_RST;
        pb_value_override_en = `PB_PAD_RST;
        pb_value_override_val = `PB_PAD_RST;
        // data-in of the master, so the master forces it to input
        pb_pullup_override_en[`PB_MISO_BIT] = spi_master;
        pb_direction_override_en[`PB_MISO_BIT] = spi_master;
        pb_puov[`PB_MISO_BIT] = out_bit_pb_bit3 & forced_pullup_ok;
        pb_value_override_en[`PB_MISO_BIT] = spi_slave;
        pb_value_override_val[`PB_MISO_BIT] = i_spi_slave_out;
        // data-out of the master; slave input otherwise
        pb_pullup_override_en[`PB_MOSI_BIT] = spi_slave;
        pb_direction_override_en[`PB_MOSI_BIT] = spi_slave;
        pb_puov[`PB_MOSI_BIT] = out_bit_pb_bit2 & forced_pullup_ok;
        pb_value_override_en[`PB_MOSI_BIT] = spi_master;
        pb_value_override_val[`PB_MOSI_BIT] = i_spi_serial_master_select_out;
        // serial clock
        pb_pullup_override_en[`PB_SCK_BIT] = spi_slave;
        pb_direction_override_en[`PB_SCK_BIT] = spi_slave;
        pb_puov[`PB_SCK_BIT] = out_bit_pb_bit1 & forced_pullup_ok;
        pb_value_override_en[`PB_SCK_BIT] = spi_master;
        pb_value_override_val[`PB_SCK_BIT] = i_spi_sck_out;
        // slave select is never driven by the serial block
        pb_pullup_override_en[`PB_SS_BIT] = spi_slave;
        pb_direction_override_en[`PB_SS_BIT] = spi_slave;
        pb_puov[`PB_SS_BIT] = out_bit_pb_bit0 & forced_pullup_ok;
        // timer compare outputs need the direction bit set by software
        pb_value_override_en[`PB_TIMER_MSB:`PB_TIMER_LSB] = i_timer_cmp_en;
        pb_value_override_val[`PB_TIMER_MSB:`PB_TIMER_LSB] = i_timer_cmp_val;
    end

    // in master mode direction_override_en is low on bits 2 to 0, so their direction bits pass untouched
    assign pb_dir_cell = {i_pb_dir_bits[`PB_WIDTH-1:`PB_MISO_BIT], dir_bit_pb_bit2,
        dir_bit_pb_bit1, dir_bit_pb_bit0};

    assign pb_dieoe = i_pb_change_mask & {`PB_WIDTH{i_pin_change_group1_enable}};

    pin_override_cell #(
        .WIDTH(`PB_WIDTH)
    ) u_pb_cell (
        .i_dir_bits(pb_dir_cell),
        .i_out_bits(i_pb_out_bits),
        .i_global_pullup_disable(i_global_pullup_disable),
        .i_sleep_din_off(i_sleep_din_off),
        .i_pullup_override_en(pb_pullup_override_en),
        .i_pullup_override_val(pb_puov),
        .i_direction_override_en(pb_direction_override_en),
        .i_direction_override_val(`PB_PAD_RST),
        .i_value_override_en(pb_value_override_en),
        .i_value_override_val(pb_value_override_val),
        .i_din_override_en(pb_dieoe),
        .i_din_override_val(pb_dieoe),
        .i_pad_in(i_pb_pad_in),
        .o_drive_en(pb_drive_en),
        .o_drive_val(pb_drive_val),
        .o_pullup_en(pb_pullup_en),
        .o_din(pb_din)
    );

    // port D: only the interrupt input keeps its pin awake
    assign pd_dieoe = {i_ext_irq_zero_enable, 1'b0};
    assign pd_dieov = {i_ext_irq_zero_enable, 1'b0};

    pin_override_cell #(
        .WIDTH(`PD_WIDTH)
    ) u_pd_cell (
        .i_dir_bits(i_pd_dir_bits),
        .i_out_bits(i_pd_out_bits),
        .i_global_pullup_disable(i_global_pullup_disable),
        .i_sleep_din_off(i_sleep_din_off),
        .i_pullup_override_en(`PD_PAD_RST),
        .i_pullup_override_val(`PD_PAD_RST),
        .i_direction_override_en(`PD_PAD_RST),
        .i_direction_override_val(`PD_PAD_RST),
        .i_value_override_en(`PD_PAD_RST),
        .i_value_override_val(`PD_PAD_RST),
        .i_din_override_en(pd_dieoe),
        .i_din_override_val(pd_dieov),
        .i_pad_in(i_pd_pad_in),
        .o_drive_en(pd_drive_en),
        .o_drive_val(pd_drive_val),
        .o_pullup_en(pd_pullup_en),
        .o_din(pd_din)
    );

    // port E bits 7 and 6
    clock_out_divider u_divided_sysclk_out (
        .i_sys_clk(i_sys_clk),
        .i_por_arst_n(i_por_arst_n),
        .o_clk_div(divided_sysclk_out)
    );

    always @* begin
        pe_direction_override_en = `PE_PAD_RST;
        pe_direction_override_val = `PE_PAD_RST;
        pe_value_override_en = `PE_PAD_RST;
        pe_value_override_val = `PE_PAD_RST;
        pe_direction_override_en[`PE_DIVIDED_SYSCLK_OUT_IDX] = i_clock_output_fuse;
        pe_direction_override_val[`PE_DIVIDED_SYSCLK_OUT_IDX] = 1'b1;
        pe_value_override_en[`PE_DIVIDED_SYSCLK_OUT_IDX] = i_clock_output_fuse;
        pe_value_override_val[`PE_DIVIDED_SYSCLK_OUT_IDX] = divided_sysclk_out;
        pe_value_override_en[`PE_SERIAL_DO_IDX] = i_usi_three_wire;
        pe_value_override_val[`PE_SERIAL_DO_IDX] = i_usi_data_out;
    end

    assign pe_dieoe = i_pe_change_mask & {`PE_WIDTH{i_pin_change_group0_enable}};

    pin_override_cell #(
        .WIDTH(`PE_WIDTH)
    ) u_pe_cell (
        .i_dir_bits(i_pe_dir_bits),
        .i_out_bits(i_pe_out_bits),
        .i_global_pullup_disable(i_global_pullup_disable),
        .i_sleep_din_off(i_sleep_din_off),
        .i_pullup_override_en(`PE_PAD_RST),
        .i_pullup_override_val(`PE_PAD_RST),
        .i_direction_override_en(pe_direction_override_en),
        .i_direction_override_val(pe_direction_override_val),
        .i_value_override_en(pe_value_override_en),
        .i_value_override_val(pe_value_override_val),
        .i_din_override_en(pe_dieoe),
        .i_din_override_val(pe_dieoe),
        .i_pad_in(i_pe_pad_in),
        .o_drive_en(pe_drive_en),
        .o_drive_val(pe_drive_val),
        .o_pullup_en(pe_pullup_en),
        .o_din(pe_din)
    );

    // registered pad controls; reset leaves every pin an input, no pull-up, except E7 while the clock fuse is set
    always @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pb_out_reg <= `PB_PAD_RST;
            pb_oe_reg <= `PB_PAD_RST;
            pb_pu_reg <= `PB_PAD_RST;
            pd_out_reg <= `PD_PAD_RST;
            pd_oe_reg <= `PD_PAD_RST;
            pd_pu_reg <= `PD_PAD_RST;
            pe_out_reg <= `PE_PAD_RST;
            pe_oe_reg <= `PE_PAD_RST;
            pe_pu_reg <= `PE_PAD_RST;
        end else begin
            pb_out_reg <= pb_drive_val;
            pb_oe_reg <= pb_drive_en;
            pb_pu_reg <= pb_pullup_en;
            pd_out_reg <= pd_drive_val;
            pd_oe_reg <= pd_drive_en;
            pd_pu_reg <= pd_pullup_en;
            pe_out_reg <= pe_drive_val;
            pe_oe_reg <= pe_drive_en;
            pe_pu_reg <= pe_pullup_en;
        end
    end

    assign o_pb_pad_out = pb_out_reg;
    assign o_pb_pad_oe = pb_oe_reg;
    assign o_pb_pullup = pb_pu_reg;
    assign o_pd_pad_out = pd_out_reg;
    assign o_pd_pad_oe = pd_oe_reg;
    assign o_pd_pullup = pd_pu_reg;

    // the clock pin bypasses the reset-cleared flops so it keeps running
    // under system reset; the divider flop itself is the data register
    assign o_pe_pad_out = i_clock_output_fuse
        ? {divided_sysclk_out, pe_out_reg[`PE_SERIAL_DO_IDX]}
        : pe_out_reg;
    assign o_pe_pad_oe = i_clock_output_fuse
        ? {1'b1, pe_oe_reg[`PE_SERIAL_DO_IDX]}
        : pe_oe_reg;
    assign o_pe_pullup = i_clock_output_fuse
        ? {1'b0, pe_pu_reg[`PE_SERIAL_DO_IDX]}
        : pe_pu_reg;

    // inputs toward peripherals; they synchronise on their own side
    assign o_pb_pin_change_src = pb_din;
    assign o_pe_pin_change_src = pe_din;
    assign o_ext_irq_zero = pd_din[`PD_EXT_IRQ_BIT];
    assign o_capture_input_timer16 = pd_din[`PD_CAPTURE_BIT];
    assign o_spi_serial_master_select_in = pb_din[`PB_MISO_BIT];
    assign o_spi_slave_in = pb_din[`PB_MOSI_BIT];
    assign o_spi_sck_in = pb_din[`PB_SCK_BIT];
    assign o_spi_slave_select_n = pb_din[`PB_SS_BIT];
    assign o_spi_slave_active = spi_slave & ~pb_din[`PB_SS_BIT];
endmodule

//--- bench/periph_stub_model.sv
module periph_stub_model (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_run,
    output logic o_serial_master_select_out,
    output logic o_slave_out,
    output logic o_sck_out,
    output logic o_usi_do,
    output logic [3:0] o_cmp_val
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg;
    // held still unless run, so the bench can predict the levels
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_reg <= 8'h5a;
        end else if (i_run) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
    // master and slave data leave on separate lines by role
    assign o_serial_master_select_out = cnt_reg[0];
    assign o_sck_out = cnt_reg[1];
    assign o_slave_out = cnt_reg[2];
    assign o_usi_do = cnt_reg[3];
    assign o_cmp_val = cnt_reg[7:4];
endmodule

//--- bench/port_alternate_function_override_assertions.sv
module port_alternate_function_override_assertions (
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    input wire logic i_por_arst_n,
    input wire logic [7:0] i_pb_dir_bits,
    input wire logic [7:0] i_pb_out_bits,
    input wire logic i_global_pullup_disable,
    input wire logic i_sleep_din_off,
    input wire logic i_serial_periph_enable,
    input wire logic i_serial_master_select,
    input wire logic i_spi_serial_master_select_out,
    input wire logic i_spi_sck_out,
    input wire logic [3:0] i_timer_cmp_en,
    input wire logic [3:0] i_timer_cmp_val,
    input wire logic i_ext_irq_zero_enable,
    input wire logic i_clock_output_fuse,
    input wire logic [7:0] i_pb_pad_in,
    input wire logic [1:0] i_pd_pad_in,
    input wire logic [7:0] o_pb_pad_out,
    input wire logic [7:0] o_pb_pad_oe,
    input wire logic [7:0] o_pb_pullup,
    input wire logic [1:0] o_pe_pad_out,
    input wire logic [1:0] o_pe_pad_oe,
    input wire logic o_ext_irq_zero,
    input wire logic o_spi_slave_active
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    wire slv = i_serial_periph_enable & ~i_serial_master_select;
    wire mst = i_serial_periph_enable & i_serial_master_select;
    a_slave_forces_in: assert property ($past(i_arst_n) && $past(slv) |-> o_pb_pad_oe[2:0] == 3'h0)
        else $error("slave pins not forced to input");
    a_master_dir_bits: assert property ($past(i_arst_n) && $past(mst)
        |-> o_pb_pad_oe[2:0] == $past(i_pb_dir_bits[2:0]))
        else $error("master pin direction not from direction bits");
    a_forced_pullup: assert property ($past(i_arst_n) && $past(slv) |-> o_pb_pullup[2:0]
        == $past(i_pb_out_bits[2:0] & {3{~i_global_pullup_disable}}))
        else $error("forced input pull-up wrong");
    a_plain_pullup: assert property ($past(i_arst_n) && !$past(i_serial_periph_enable)
        |-> o_pb_pullup == $past(~i_pb_dir_bits & i_pb_out_bits
        & {8{~i_global_pullup_disable}}))
        else $error("plain pull-up wrong");
    a_master_values: assert property ($past(i_arst_n) && $past(mst) |-> ((o_pb_pad_out[2:1]
        ^ $past({i_spi_serial_master_select_out, i_spi_sck_out})) & o_pb_pad_oe[2:1]) == 2'h0)
        else $error("master data or clock level wrong");
    a_timer_values: assert property ($past(i_arst_n) |-> ((o_pb_pad_out[7:4]
        ^ $past(i_timer_cmp_val)) & o_pb_pad_oe[7:4] & $past(i_timer_cmp_en)) == 4'h0)
        else $error("compare output level wrong");
    a_slave_select: assert property (!i_sleep_din_off
        |-> o_spi_slave_active == (slv & ~i_pb_pad_in[0]))
        else $error("slave activity does not follow select pin");
    a_ext_irq_route: assert property (i_ext_irq_zero_enable
        |-> o_ext_irq_zero == i_pd_pad_in[1])
        else $error("external interrupt input not routed");
    // judged under power-on reset only: it must keep running in system reset
    a_clock_out_runs: assert property (@(posedge i_sys_clk) disable iff (!i_por_arst_n)
        i_clock_output_fuse && $past(i_clock_output_fuse) && $past(i_por_arst_n)
        |-> o_pe_pad_oe[1] && o_pe_pad_out[1] != $past(o_pe_pad_out[1]))
        else $error("divided clock output not toggling");
    c_slave: cover property (slv && o_spi_slave_active);
    c_master: cover property (mst && o_pb_pad_oe[2]);
    c_divided_sysclk_out_rst: cover property (@(posedge i_sys_clk) disable iff (!i_por_arst_n)
        !i_arst_n && o_pe_pad_oe[1]);
endmodule
bind port_alternate_function_override port_alternate_function_override_assertions u_chk (.*);

//--- bench/port_alternate_function_override_tb.sv
module port_alternate_function_override_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 0, i_arst_n = 0, i_por_arst_n = 0, run = 0, v;
    logic [7:0] i_pb_dir_bits = 0, i_pb_out_bits = 0, i_pb_pad_in = 0, i_pb_change_mask = 0;
    logic [1:0] i_pd_dir_bits = 0, i_pd_out_bits = 0, i_pd_pad_in = 0;
    logic [1:0] i_pe_dir_bits = 0, i_pe_out_bits = 0, i_pe_pad_in = 0, i_pe_change_mask = 0;
    logic i_global_pullup_disable = 0, i_sleep_din_off = 0;
    logic i_serial_periph_enable = 0, i_serial_master_select = 0;
    logic i_pin_change_group1_enable = 0, i_pin_change_group0_enable = 0;
    logic i_ext_irq_zero_enable = 0, i_clock_output_fuse = 1, i_usi_three_wire = 0;
    logic [3:0] i_timer_cmp_en = 0;
    wire i_spi_serial_master_select_out, i_spi_slave_out, i_spi_sck_out, i_usi_data_out;
    wire [3:0] i_timer_cmp_val;
    wire [7:0] o_pb_pad_out, o_pb_pad_oe, o_pb_pullup, o_pb_pin_change_src;
    wire [1:0] o_pd_pad_out, o_pd_pad_oe, o_pd_pullup;
    wire [1:0] o_pe_pad_out, o_pe_pad_oe, o_pe_pullup, o_pe_pin_change_src;
    wire o_ext_irq_zero, o_capture_input_timer16, o_spi_serial_master_select_in, o_spi_slave_in;
    wire o_spi_sck_in, o_spi_slave_select_n, o_spi_slave_active;
    int fail_count = 0, n_compared = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    port_alternate_function_override dut (.*);
    periph_stub_model u_periph (.i_sys_clk, .i_arst_n, .i_run(run), .o_serial_master_select_out(i_spi_serial_master_select_out),
        .o_slave_out(i_spi_slave_out), .o_sck_out(i_spi_sck_out), .o_usi_do(i_usi_data_out),
        .o_cmp_val(i_timer_cmp_val));
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // pad controls are registered, so one edge before looking
    task step;
        @(posedge i_sys_clk);
        #1;
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge i_sys_clk);
        fail_count++;
        report_and_stop;
    end
    initial begin
        repeat (2) @(posedge i_sys_clk);
        i_por_arst_n <= 1;
        repeat (5) @(posedge i_sys_clk);
        #1;
        v = o_pe_pad_out[1];
        chk("rst_oe", 8'h00, o_pb_pad_oe);
        chk("divided_sysclk_out_oe", 8'h01, o_pe_pad_oe[1]);
        step;
        chk("divided_sysclk_out_tgl", {7'h00, ~v}, o_pe_pad_out[1]);
        @(posedge i_sys_clk);
        i_arst_n <= 1;
        $display("test reset done");
        @(posedge i_sys_clk);
        {i_serial_periph_enable, i_pb_dir_bits, i_pb_out_bits, i_pb_pad_in} <= {1'b1, 24'hff0706};
        step;
        chk("slv_oe", 8'hf8, o_pb_pad_oe);
        chk("slv_pu", 8'h07, o_pb_pullup[2:0]);
        chk("slv_miso", i_spi_slave_out, o_pb_pad_out[3]);
        chk("slv_in", 8'h01, o_spi_slave_in);
        chk("slv_act", 8'h01, o_spi_slave_active);
        chk("slv_sck_in", 8'h01, o_spi_sck_in);
        @(posedge i_sys_clk);
        {i_global_pullup_disable, i_pb_pad_in} <= {1'b1, 8'h01};
        step;
        chk("slv_pud", 8'h00, o_pb_pullup[2:0]);
        chk("slv_idle", 8'h00, o_spi_slave_active);
        chk("slv_ss_n", 8'h01, o_spi_slave_select_n);
        $display("test slave done");
        @(posedge i_sys_clk);
        {i_serial_master_select, i_global_pullup_disable} <= 2'b10;
        {i_pb_dir_bits, i_pb_pad_in} <= 16'h0d08;
        step;
        chk("mst_oe", 8'h05, o_pb_pad_oe[3:0]);
        chk("mst_in", 8'h01, o_spi_serial_master_select_in);
        chk("mst_mosi", i_spi_serial_master_select_out, o_pb_pad_out[2]);
        @(posedge i_sys_clk);
        i_pb_dir_bits <= 8'h07;
        step;
        chk("mst_sck", {i_spi_serial_master_select_out, i_spi_sck_out}, o_pb_pad_out[2:1]);
        $display("test master done");
        @(posedge i_sys_clk);
        {i_serial_periph_enable, i_pb_dir_bits, i_pb_out_bits} <= {1'b0, 16'hf03c};
        i_timer_cmp_en <= 4'hf;
        step;
        chk("plain_pu", 8'h0c, o_pb_pullup);
        chk("tmr_val", i_timer_cmp_val, o_pb_pad_out[7:4]);
        chk("tmr_oe", 8'hf0, o_pb_pad_oe);
        @(posedge i_sys_clk);
        i_global_pullup_disable <= 1;
        step;
        chk("pud_pu", 8'h00, o_pb_pullup);
        $display("test plain done");
        @(posedge i_sys_clk);
        {i_sleep_din_off, i_pb_change_mask, i_pin_change_group1_enable} <= 10'h3ff;
        {i_pb_pad_in, i_pe_change_mask, i_pin_change_group0_enable} <= 11'h52d;
        {i_pe_pad_in, i_ext_irq_zero_enable, i_pd_pad_in} <= 5'h1f;
        step;
        chk("pcs_b", 8'ha5, o_pb_pin_change_src);
        chk("pcs_e", 8'h02, o_pe_pin_change_src);
        chk("irq0", 8'h01, o_ext_irq_zero);
        @(posedge i_sys_clk);
        i_pin_change_group1_enable <= 0;
        step;
        chk("pcs_off", 8'h00, o_pb_pin_change_src);
        @(posedge i_sys_clk);
        {i_sleep_din_off, i_pd_dir_bits, i_pd_out_bits} <= 5'h0d;
        step;
        chk("pd_oe", 8'h03, o_pd_pad_oe);
        chk("pd_out", 8'h01, o_pd_pad_out);
        chk("capture", 8'h01, o_capture_input_timer16);
        @(posedge i_sys_clk);
        {i_clock_output_fuse, i_pe_dir_bits, i_pe_out_bits, i_usi_three_wire} <= 6'h0d;
        i_global_pullup_disable <= 0;
        step;
        chk("pe_out", {1'b1, i_usi_data_out}, o_pe_pad_out);
        chk("pe_oe", 8'h01, o_pe_pad_oe);
        chk("pe_pu", 8'h02, o_pe_pullup);
        chk("pd_pu", 8'h00, o_pd_pullup);
        $display("test ports done");
        @(posedge i_sys_clk);
        {run, i_serial_periph_enable, i_serial_master_select, i_global_pullup_disable} <= 4'he;
        {i_pb_dir_bits, i_clock_output_fuse} <= 9'h1ff;
        repeat (20) @(posedge i_sys_clk);
        i_serial_master_select <= 0;
        repeat (20) @(posedge i_sys_clk);
        i_arst_n <= 0;
        step;
        chk("rst2_oe", 8'h00, o_pb_pad_oe);
        chk("rst2_divided_sysclk_out", 8'h01, o_pe_pad_oe[1]);
        @(posedge i_sys_clk);
        i_arst_n <= 1;
        repeat (4) @(posedge i_sys_clk);
        $display("test traffic done");
        report_and_stop;
    end
endmodule
